// ===== adc_primary_control.sv
`timescale 1ns/1ps
module adc_primary_control
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // axi4-lite write address
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // trigger pins
   input  wire trig_in_t    trig_raw,
   // converter core controls
   output logic             sample_hold,
   output logic             conv_start,
   output logic             res12_mode,
   output logic             ext_dma_on,
   output logic             ext_buf_mode,
   output logic             scan_enable_bad,
   // interrupt
   output logic             irq
);

   ctrl_fields_t ctrl_reg;
   ctrl_fields_t ctrl_next;
   conv_state_t  state_reg;
   conv_state_t  state_next;
   logic         sample_enable_reg;
   logic         sample_enable_next;
   logic         done_reg;
   logic         done_next;
   logic [7:0]   scnt_reg;
   logic [7:0]   scnt_next;
   logic [4:0]   ccnt_reg;
   logic [4:0]   ccnt_next;
   logic [1:0]   ista_reg;
   logic [1:0]   ista_next;
   logic [1:0]   imask_reg;
   logic [1:0]   imask_next;
   logic [3:0]   awaddr_reg;
   logic         aw_held_reg;
   logic [31:0]  wdata_reg;
   logic [3:0]   wstrb_reg;
   logic         w_held_reg;
   logic         bvalid_reg;
   logic [1:0]   bresp_reg;
   logic         rvalid_reg;
   logic [31:0]  rdata_reg;
   logic [1:0]   rresp_reg;
   logic         conv_start_reg;
   trig_in_t     trig_pulse;

   adc_trigger_sync u_sync (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .trig_raw   (trig_raw),
      .trig_pulse (trig_pulse)
   );

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a[3:2] == off[3:2]);
   endfunction

   // write channel capture; either order of address and data is accepted
   wire do_write   = aw_held_reg && w_held_reg && !bvalid_reg;
   wire wr_ctrl    = do_write && hit(awaddr_reg, ctrl_off);
   wire wr_ista    = do_write && hit(awaddr_reg, ista_off);
   wire wr_imask   = do_write && hit(awaddr_reg, imask_off);
   wire wr_stat    = do_write && hit(awaddr_reg, stat_off);
   wire wr_mapped  = wr_ctrl || wr_ista || wr_imask || wr_stat;
   wire [15:0] wr_bits = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
                          wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};
   wire [15:0] wr_lane = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // control word as software sees it
   wire [15:0] ctrl_word = {ctrl_reg.converter_on, 1'b0, ctrl_reg.idle_halt_select,
                            ctrl_reg.extended_buffer_mode_select,
                            ctrl_reg.extended_dma_enable, ctrl_reg.resolution_select,
                            ctrl_reg.result_format, ctrl_reg.trigger_source_select,
                            1'b0, ctrl_reg.auto_sample_enable, sample_enable_reg, done_reg};
   wire [15:0] ctrl_new  = (ctrl_word & ~wr_lane) | (wr_bits & wr_lane & ctrl_wmask);

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next.converter_on                = ctrl_new[on_pos];
         ctrl_next.idle_halt_select            = ctrl_new[idle_pos];
         ctrl_next.extended_buffer_mode_select = ctrl_new[bufmode_pos];
         ctrl_next.extended_dma_enable         = ctrl_new[dma_pos];
         ctrl_next.resolution_select           = ctrl_new[res_pos];
         ctrl_next.result_format               = ctrl_new[fmt_pos +: 2];
         ctrl_next.trigger_source_select       = ctrl_new[trig_pos +: 4];
         ctrl_next.auto_sample_enable          = ctrl_new[auto_sample_enable_pos];
      end
   end

   // core steering outputs
   assign ext_dma_on      = ctrl_reg.extended_dma_enable;
   assign ext_buf_mode    = ctrl_reg.extended_dma_enable &&
                            ctrl_reg.extended_buffer_mode_select;
   assign res12_mode      = ctrl_reg.resolution_select;
   assign sample_hold     = sample_enable_reg;
   assign conv_start      = conv_start_reg;
   // auto-convert is not allowed with auto-scan; flagged for the scan logic
   assign scan_enable_bad = (ctrl_reg.trigger_source_select == trig_autoconv);

   // trigger selection
   wire [3:0] tsel = ctrl_reg.trigger_source_select;
   wire sw_sample_enable_wr = wr_ctrl && wstrb_reg[0];
   wire sw_end     = sw_sample_enable_wr && !wdata_reg[sample_enable_pos];
   wire sw_start   = sw_sample_enable_wr && wdata_reg[sample_enable_pos];
   logic end_sample;
   always_comb begin
      case (tsel)
         trig_manual:   end_sample = sw_end;
         trig_int0:     end_sample = trig_pulse.ext_int_trigger;
         trig_timer3:   end_sample = trig_pulse.timer_three_trigger;
         trig_timer5:   end_sample = trig_pulse.timer_five_trigger;
         trig_charge_time_unit_trigger:     end_sample = trig_pulse.charge_time_unit_trigger;
         trig_timer1:   end_sample = trig_pulse.timer_one_trigger;
         trig_autoconv: end_sample = (scnt_reg == auto_sample_cycles);
         default:       end_sample = 1'b0;
      endcase
   end
   // unimplemented codes never end sampling; that is the error event
   wire bad_code = (tsel == trig_unimpl) || (tsel > trig_autoconv);

   wire [4:0] conv_len = ctrl_reg.resolution_select ? conv12_cycles : conv10_cycles;
   wire conv_done  = (state_reg == st_conv) && (ccnt_reg == conv_len);
   wire clear_done = wr_ctrl && wstrb_reg[0] && !wdata_reg[done_pos];

   // conversion sequencer
   always_comb begin
      state_next = state_reg;
      sample_enable_next  = sample_enable_reg;
      done_next  = done_reg;
      scnt_next  = scnt_reg;
      ccnt_next  = ccnt_reg;
      if (clear_done) begin
         done_next = 1'b0;
      end
      case (state_reg)
         st_idle: begin
            if (ctrl_reg.converter_on && sw_start) begin
               state_next = st_sample;
               sample_enable_next  = 1'b1;
               done_next  = 1'b0;
               scnt_next  = 8'h00;
            end
         end
         st_sample: begin
            scnt_next = scnt_reg + 8'h01;
            if (!ctrl_reg.converter_on) begin
               state_next = st_idle;
               sample_enable_next  = 1'b0;
            end else if (end_sample) begin
               state_next = st_conv;
               sample_enable_next  = 1'b0;
               ccnt_next  = 5'h00;
            end
         end
         st_conv: begin
            ccnt_next = ccnt_reg + 5'h01;
            if (!ctrl_reg.converter_on) begin
               state_next = st_idle;
            end else if (conv_done) begin
               done_next = 1'b1;
               if (ctrl_reg.auto_sample_enable) begin
                  state_next = st_sample;
                  sample_enable_next  = 1'b1;
                  scnt_next  = 8'h00;
               end else begin
                  state_next = st_idle;
               end
            end
         end
         default: begin
            state_next = st_idle;
            sample_enable_next  = 1'b0;
         end
      endcase
   end

   // interrupts: set wins over write-one-to-clear
   wire [1:0] ev = {(state_reg == st_sample) && bad_code, conv_done};
   wire [1:0] w1c = wr_ista ? wdata_reg[1:0] & {2{wstrb_reg[0]}} : 2'h0;
   assign ista_next  = (ista_reg & ~w1c) | ev;
   assign imask_next = (wr_imask && wstrb_reg[0]) ? wdata_reg[1:0] : imask_reg;
   assign irq        = |(ista_reg & imask_reg);

   // read decode
   wire [3:0] ra = s_axi_araddr;
   wire rd_ok = hit(ra, ctrl_off) || hit(ra, stat_off) || hit(ra, ista_off) ||
                hit(ra, imask_off);
   wire [31:0] rd_val = hit(ra, ctrl_off)  ? {16'h0000, ctrl_word} :
                        hit(ra, stat_off)  ? {29'h0, state_reg} :
                        hit(ra, ista_off)  ? {30'h0, ista_reg} :
                        hit(ra, imask_off) ? {30'h0, imask_reg} : 32'h0;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg       <= ctrl_fields_t'(12'h000);
         state_reg      <= st_idle;
         sample_enable_reg       <= ctrl_reset[sample_enable_pos];
         done_reg       <= ctrl_reset[done_pos];
         scnt_reg       <= 8'h00;
         ccnt_reg       <= 5'h00;
         ista_reg       <= irq_reset;
         imask_reg      <= irq_reset;
         conv_start_reg <= 1'b0;
      end else begin
         ctrl_reg       <= ctrl_next;
         state_reg      <= state_next;
         sample_enable_reg       <= sample_enable_next;
         done_reg       <= done_next;
         scnt_reg       <= scnt_next;
         ccnt_reg       <= ccnt_next;
         ista_reg       <= ista_next;
         imask_reg      <= imask_next;
         conv_start_reg <= (state_reg == st_sample) && (state_next == st_conv);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 4'h0;
         wdata_reg   <= 32'h0;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= resp_okay;
      end else begin
         if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? resp_okay : resp_slverr;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0;
         rresp_reg  <= resp_okay;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_val;
         rresp_reg  <= rd_ok ? resp_okay : resp_slverr;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule

// ===== adc_ctrl_pkg.sv
package adc_ctrl_pkg;

   // register byte offsets
   localparam logic [3:0] ctrl_off  = 4'h0;
   localparam logic [3:0] stat_off  = 4'h4;
   localparam logic [3:0] ista_off  = 4'h8;
   localparam logic [3:0] imask_off = 4'hc;

   // control word field positions
   localparam int on_pos      = 15;
   localparam int idle_pos    = 13;
   localparam int bufmode_pos = 12;
   localparam int dma_pos     = 11;
   localparam int res_pos     = 10;
   localparam int fmt_pos     = 8;
   localparam int trig_pos    = 4;
   localparam int auto_sample_enable_pos    = 2;
   localparam int sample_enable_pos    = 1;
   localparam int done_pos    = 0;

   localparam logic [15:0] ctrl_reset = 16'h0000;
   localparam logic [15:0] ctrl_wmask = 16'hbffe;

   // trigger source codes
   localparam logic [3:0] trig_manual   = 4'h0;
   localparam logic [3:0] trig_int0     = 4'h1;
   localparam logic [3:0] trig_timer3   = 4'h2;
   localparam logic [3:0] trig_timer5   = 4'h3;
   localparam logic [3:0] trig_charge_time_unit_trigger     = 4'h4;
   localparam logic [3:0] trig_timer1   = 4'h5;
   localparam logic [3:0] trig_unimpl   = 4'h6;
   localparam logic [3:0] trig_autoconv = 4'h7;

   // interrupt status bits
   localparam int irq_done_pos = 0;
   localparam int irq_err_pos  = 1;
   localparam logic [1:0] irq_reset = 2'h0;

   // timing counts in cycles of sys_clk
   localparam logic [7:0] auto_sample_cycles = 8'h1f;
   localparam logic [4:0] conv10_cycles      = 5'h0c;
   localparam logic [4:0] conv12_cycles      = 5'h0e;

   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   typedef struct packed {
      logic       converter_on;
      logic       idle_halt_select;
      logic       extended_buffer_mode_select;
      logic       extended_dma_enable;
      logic       resolution_select;
      logic [1:0] result_format;
      logic [3:0] trigger_source_select;
      logic       auto_sample_enable;
   } ctrl_fields_t;

   typedef struct packed {
      logic timer_one_trigger;
      logic timer_five_trigger;
      logic charge_time_unit_trigger;
      logic timer_three_trigger;
      logic ext_int_trigger;
   } trig_in_t;

   typedef enum logic [2:0] {
      st_idle   = 3'b001,
      st_sample = 3'b010,
      st_conv   = 3'b100
   } conv_state_t;

endpackage

// ===== adc_trigger_sync.sv
`timescale 1ns/1ps
module adc_trigger_sync
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst_n,
   // raw trigger pins
   input  wire trig_in_t trig_raw,
   // one-cycle rising-edge pulses
   output trig_in_t      trig_pulse
);

   logic [4:0] s1_reg;
   logic [4:0] s2_reg;
   logic [4:0] s3_reg;
   logic [4:0] level_reg;
   logic [4:0] level_next;
   logic [4:0] rise;

   // a change counts once stages two and three agree
   assign level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
   assign rise       = level_next & ~level_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg     <= 5'h00;
         s2_reg     <= 5'h00;
         s3_reg     <= 5'h00;
         level_reg  <= 5'h00;
         trig_pulse <= '0;
      end else begin
         s1_reg     <= trig_raw;
         s2_reg     <= s1_reg;
         s3_reg     <= s2_reg;
         level_reg  <= level_next;
         trig_pulse <= rise;
      end
   end

endmodule

// ===== adc_primary_control_sva.sv
`timescale 1ns/1ps
module adc_primary_control_sva
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // converter core controls
   input wire logic sample_hold,
   input wire logic conv_start,
   input wire logic res12_mode,
   input wire logic ext_dma_on,
   input wire logic ext_buf_mode,
   input wire logic scan_enable_bad
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // config outputs may only move with a completed write
   sequence write_done;
      $rose(s_axi_bvalid);
   endsequence

   sequence conv_hold;
      !sample_hold [*8];
   endsequence

   buf_gate_a: assert property (ext_buf_mode |-> ext_dma_on)
      else $error("buffer mode active without extended dma");
   dma_by_write_a: assert property ($changed(ext_dma_on) |-> write_done)
      else $error("extended dma output moved without a write");
   res_by_write_a: assert property ($changed(res12_mode) |-> write_done)
      else $error("resolution output moved without a write");
   code_by_write_a: assert property ($changed(scan_enable_bad) |-> write_done)
      else $error("bad scan flag moved without a write");
   start_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   conv_hold_a: assert property (conv_start |-> !sample_hold ##1 conv_hold)
      else $error("sampling during conversion");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write accepted before response");
endmodule

bind adc_primary_control adc_primary_control_sva sva_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .sample_hold(sample_hold),
   .conv_start(conv_start), .res12_mode(res12_mode), .ext_dma_on(ext_dma_on),
   .ext_buf_mode(ext_buf_mode), .scan_enable_bad(scan_enable_bad)
);

// ===== test_adc_primary_control.sv
`timescale 1ns/1ps
module test_adc_primary_control;
   import adc_ctrl_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   trig_in_t    trig_raw = '0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, rd_val;
   logic        sample_hold, conv_start, res12_mode, ext_dma_on, ext_buf_mode;
   logic        scan_enable_bad, irq;
   int          failures = 0, tests_run = 0, since_start = 0, n10, n12;

   adc_primary_control DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .trig_raw(trig_raw), .sample_hold(sample_hold), .conv_start(conv_start),
      .res12_mode(res12_mode), .ext_dma_on(ext_dma_on), .ext_buf_mode(ext_buf_mode),
      .scan_enable_bad(scan_enable_bad), .irq(irq)
   );

   always #50 sys_clk = ~sys_clk;

   // edges since the last conversion start, so 10 and 12-bit lengths can be compared
   always @(posedge sys_clk) since_start <= conv_start ? 0 : since_start + 1;

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // outputs are sampled at the falling edge, where they are settled
   // bready and rready stay high between calls, so no step assigns them twice
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic       ta, tw, tb;
      logic [1:0] r;
      tb = 1'b0;
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb) begin
         @(negedge sys_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge sys_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      chk(r, resp_okay);
   endtask

   // arvalid is held through the edge at which it is taken
   task automatic rd(input logic [3:0] a);
      logic       ta, tr;
      logic [1:0] r;
      tr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr) begin
         @(negedge sys_clk);
         ta = arvalid && arready;
         tr = rvalid;
         rd_val = rdata;
         r = rresp;
         @(posedge sys_clk);
         if (ta) arvalid <= 1'b0;
      end
      chk(r, resp_okay);
   endtask

   task automatic wait_irq(output int cyc);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 300) failures++;
      cyc = since_start;
      @(posedge sys_clk);
   endtask

   // one conversion; a trigger code of zero ends sampling by software
   task automatic conv(input logic [15:0] cw, output int cyc);
      // sampling starts only once the converter is already on
      wr(ctrl_off, cw | 16'h8000);
      wr(ctrl_off, cw | 16'h8002);
      chk(sample_hold, 1'b1);
      if (cw[7:4] == trig_manual) begin
         wr(ctrl_off, cw | 16'h8000);
      end else begin
         case (cw[7:4])
            trig_timer5: trig_raw.timer_five_trigger <= 1'b1;
            trig_charge_time_unit_trigger:   trig_raw.charge_time_unit_trigger <= 1'b1;
            default:     trig_raw.timer_one_trigger <= 1'b1;
         endcase
         // pulse needs the synchroniser plus one edge before sampling stops
         repeat (6) @(posedge sys_clk);
         trig_raw <= '0;
      end
      rd(ctrl_off);
      chk(rd_val[1:0], 2'b00);
      wait_irq(cyc);
      rd(ctrl_off);
      chk(rd_val[1:0], 2'b01);
      wr(ista_off, 16'h0001);
      chk(irq, 1'b0);
      wr(ctrl_off, 16'h8000);
      rd(ctrl_off);
      chk(rd_val[0], 1'b0);
   endtask

   initial begin
      #2000000;
      failures++;
      test_done;
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(ctrl_off);
      chk(rd_val, {16'h0000, ctrl_reset});
      wr(stat_off, 16'hffff);
      rd(stat_off);
      chk(rd_val, 32'h1);
      $display("test reset done");
      wr(ctrl_off, 16'h1000);
      chk({ext_dma_on, ext_buf_mode}, 2'b00);
      wr(ctrl_off, 16'h1c00);
      chk({ext_dma_on, ext_buf_mode, res12_mode}, 3'b111);
      rd(ctrl_off);
      chk(rd_val, 32'h1c00);
      wr(ctrl_off, 16'h0000);
      chk({ext_dma_on, ext_buf_mode, res12_mode}, 3'b000);
      $display("test mode bits done");
      for (int c = 0; c < 16; c++) begin
         wr(ctrl_off, 16'(c << trig_pos));
         chk(scan_enable_bad, c == 7);
         rd(ctrl_off);
         chk(rd_val, 32'(c << trig_pos));
      end
      $display("test trigger codes done");
      wr(imask_off, 16'h0001);
      conv(16'h0000, n10);
      conv(16'h0400, n12);
      chk(32'(n12 - n10), 32'd2);
      conv(16'h0050, n10);
      conv(16'h0030, n10);
      conv(16'h0040, n10);
      $display("test conversions done");
      // auto-convert with auto-sample: sampling must restart by itself
      wr(ctrl_off, 16'h8076);
      wait_irq(n10);
      repeat (2) @(posedge sys_clk);
      chk(sample_hold, 1'b1);
      rd(stat_off);
      chk(rd_val, 32'h2);
      wr(ctrl_off, 16'h0000);
      wr(ista_off, 16'h0003);
      $display("test auto sample done");
      wr(imask_off, 16'h0000);
      wr(ctrl_off, 16'h8000);
      wr(ctrl_off, 16'h8062);
      rd(ista_off);
      chk(rd_val[1], 1'b1);
      chk(irq, 1'b0);
      wr(imask_off, 16'h0002);
      chk(irq, 1'b1);
      wr(ctrl_off, 16'h0000);
      wr(ista_off, 16'h0003);
      chk(irq, 1'b0);
      $display("test bad code done");
      test_done;
   end
endmodule
